// File: ext_bus_pkg.sv
/*
 * constants for the external bus, interrupt and reset pin block.
 * assumes a 10 MHz pclk and an APB master reaching the registers.
 */
package ext_bus_pkg;
	localparam int ADDR_W = 23;
	localparam int LOW_W = 16;
	localparam int DATA_W = 16;
	localparam int NIRQ = 4;
	localparam logic [22:0] RESET_VECTOR = 23'h00FF80;
	localparam logic [15:0] NMI_VECTOR = 16'hFF84;
	localparam logic [15:0] IRQ_VECTOR_BASE = 16'hFFC0;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_FLAG = 8'h0C;
	localparam logic [7:0] OFF_ACCESS = 8'h10;
	localparam logic [7:0] OFF_WDATA = 8'h14;
	localparam logic [7:0] OFF_RDATA = 8'h18;
	localparam logic [7:0] OFF_PC = 8'h1C;
	localparam int CTRL_GIM = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_HOLDER = 2;
	localparam logic [2:0] CTRL_RESET = 3'h5;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam int ACCESS_WRITE = 24;
	localparam int ACCESS_PROG = 25;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_DRIVE = 2'b01,
		BUS_SETTLE = 2'b11,
		BUS_SAMPLE = 2'b10
	} bus_state_t;
endpackage

// File: irq_if.sv
/*
 * carries accepted-interrupt handshake between the interrupt unit and the bus top.
 * assumes a single pclk domain.
 */
`timescale 1ns/1ps
interface irq_if;
	logic [3:0] pending;
	logic take;
	logic is_nmi;
	logic [1:0] idx;
	logic accept;
	modport ctrl(output pending, output take, output is_nmi, output idx, input accept);
	modport core(input pending, input take, input is_nmi, input idx, output accept);
endinterface

// File: irq_unit.sv
/*
 * interrupt unit: synchronises four user inputs and the nonmaskable input,
 * latches flags and picks one to take. assumes pins asynchronous to pclk.
 */
`timescale 1ns/1ps
module irq_unit #(
	parameter int NIRQ = ext_bus_pkg::NIRQ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [NIRQ-1:0] irq_pin_n,
	input wire logic nmi_pin_n,
	input wire logic [NIRQ-1:0] mask,
	input wire logic gim,
	input wire logic mode,
	input wire logic [NIRQ-1:0] clr,
	output logic [NIRQ-1:0] flags,
	irq_if.ctrl ifc
);
	logic [NIRQ:0] s1_q, s2_q, s3_q;
	logic [NIRQ-1:0] rise;
	logic nmi_pend_q;
	logic [NIRQ-1:0] elig;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
		end else begin
			s1_q <= {nmi_pin_n, irq_pin_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign rise = s3_q[NIRQ-1:0] & ~s2_q[NIRQ-1:0];
	// set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~clr & ~(ifc.accept && !ifc.is_nmi ? (4'h1 << ifc.idx) : 4'h0))
				| rise;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_pend_q <= 1'b0;
		end else if (s3_q[NIRQ] && !s2_q[NIRQ]) begin
			nmi_pend_q <= 1'b1;
		end else if (ifc.accept && ifc.is_nmi) begin
			nmi_pend_q <= 1'b0;
		end
	end
	assign elig = flags & mask;
	assign ifc.pending = flags;
	always_comb begin
		ifc.take = 1'b0;
		ifc.is_nmi = 1'b0;
		ifc.idx = 2'd0;
		if (nmi_pend_q) begin
			ifc.take = 1'b1;
			ifc.is_nmi = 1'b1;
		end else if (!gim && elig != '0) begin
			ifc.take = 1'b1;
			// mode bit picks lowest or highest line first
			if (!mode) begin
				for (int i = NIRQ - 1; i >= 0; i--) begin
					if (elig[i]) ifc.idx = 2'(i);
				end
			end else begin
				for (int i = 0; i < NIRQ; i++) begin
					if (elig[i]) ifc.idx = 2'(i);
				end
			end
		end
	end
endmodule

// File: ext_bus_top.sv
/*
 * external parallel bus, interrupt acknowledge and reset vector block.
 * assumes APB master on pclk; pads resolve the three-signal pins and
 * the bus holders outside on the enables given.
 */
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module ext_bus_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reset_n,
	input wire logic hold_req_n,
	output logic hold_ack_n,
	input wire logic off_n,
	input wire logic host_wide_mode_pin,
	input wire logic [22:0] ext_addr_i,
	output logic [22:0] ext_addr_o,
	output logic [22:0] ext_addr_oe,
	input wire logic [15:0] ext_data_i,
	output logic [15:0] ext_data_o,
	output logic ext_data_oe,
	output logic ext_data_hold_en,
	output logic irq_ack_n_o,
	output logic irq_ack_n_oe,
	input wire logic [3:0] ext_irq_n,
	input wire logic nmi_n
);
	logic [2:0] rs_sync_q, hold_sync_q, off_sync_q, wide_sync_q;
	logic rs_n, hold_n, off_ok, wide;
	logic [15:0] hdata_s1_q, hdata_s2_q;
	logic [15:0] haddr_s1_q, haddr_s2_q;
	logic [2:0] ctrl_q;
	logic [3:0] mask_q;
	logic [3:0] flags;
	logic [3:0] clr;
	logic [22:0] acc_addr_q;
	logic acc_wr_q, acc_prog_q, acc_go_q;
	logic [15:0] wdata_q, rdata_q;
	logic [22:0] pc_q;
	logic ack_q;
	logic [15:0] ack_vec_q;
	ext_bus_pkg::bus_state_t st_q;
	logic apb_wr, apb_rd;
	logic start;
	irq_if irq();

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rs_sync_q <= 3'h0;
			hold_sync_q <= 3'h7;
			off_sync_q <= 3'h7;
			wide_sync_q <= 3'h0;
			hdata_s1_q <= 16'h0000;
			hdata_s2_q <= 16'h0000;
			haddr_s1_q <= 16'h0000;
			haddr_s2_q <= 16'h0000;
		end else begin
			rs_sync_q <= {rs_sync_q[1:0], reset_n};
			hold_sync_q <= {hold_sync_q[1:0], hold_req_n};
			off_sync_q <= {off_sync_q[1:0], off_n};
			wide_sync_q <= {wide_sync_q[1:0], host_wide_mode_pin};
			hdata_s1_q <= ext_data_i;
			hdata_s2_q <= hdata_s1_q;
			haddr_s1_q <= ext_addr_i[15:0];
			haddr_s2_q <= haddr_s1_q;
		end
	end
	assign rs_n = rs_sync_q[1];
	assign hold_n = hold_sync_q[1];
	assign off_ok = off_sync_q[1];
	assign wide = wide_sync_q[1];

	irq_unit #(.NIRQ(ext_bus_pkg::NIRQ)) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.irq_pin_n(ext_irq_n),
		.nmi_pin_n(nmi_n),
		.mask(mask_q),
		.gim(ctrl_q[ext_bus_pkg::CTRL_GIM]),
		.mode(ctrl_q[ext_bus_pkg::CTRL_MODE]),
		.clr(clr),
		.flags(flags),
		.ifc(irq.ctrl)
	);

	// APB: zero-wait slave, pready tied high from a flop
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign clr = (apb_wr && paddr == ext_bus_pkg::OFF_FLAG) ? pwdata[3:0] : 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= ext_bus_pkg::CTRL_RESET;
			mask_q <= ext_bus_pkg::MASK_RESET;
			wdata_q <= 16'h0000;
		end else if (apb_wr) begin
			case (paddr)
				ext_bus_pkg::OFF_CTRL: ctrl_q <= pwdata[2:0];
				ext_bus_pkg::OFF_MASK: mask_q <= pwdata[3:0];
				ext_bus_pkg::OFF_WDATA: wdata_q <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= paddr > ext_bus_pkg::OFF_PC || paddr[1:0] != 2'b00;
			unique case (paddr)
				ext_bus_pkg::OFF_CTRL: prdata <= {29'h0, ctrl_q};
				ext_bus_pkg::OFF_STATUS: prdata <= {26'h0, st_q, wide, !hold_ack_n, !rs_n, acc_go_q};
				ext_bus_pkg::OFF_MASK: prdata <= {28'h0, mask_q};
				ext_bus_pkg::OFF_FLAG: prdata <= {28'h0, flags};
				ext_bus_pkg::OFF_ACCESS: prdata <= {6'h0, acc_prog_q, acc_wr_q, 1'b0, acc_addr_q};
				ext_bus_pkg::OFF_WDATA: prdata <= {16'h0, wdata_q};
				ext_bus_pkg::OFF_RDATA: prdata <= {16'h0, rdata_q};
				ext_bus_pkg::OFF_PC: prdata <= {9'h0, pc_q};
				default: prdata <= 32'h00000000;
			endcase
		end else if (apb_rd && pslverr) begin
			prdata <= 32'h00000000;
		end
	end

	// access request: a write to ACCESS starts one external transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_addr_q <= 23'h000000;
			acc_wr_q <= 1'b0;
			acc_prog_q <= 1'b0;
			acc_go_q <= 1'b0;
		end else if (apb_wr && paddr == ext_bus_pkg::OFF_ACCESS && !acc_go_q) begin
			// upper lines only count for program space
			acc_addr_q <= pwdata[ext_bus_pkg::ACCESS_PROG] ? pwdata[22:0]
				: {7'h00, pwdata[15:0]};
			acc_wr_q <= pwdata[ext_bus_pkg::ACCESS_WRITE];
			acc_prog_q <= pwdata[ext_bus_pkg::ACCESS_PROG];
			acc_go_q <= 1'b1;
		end else if (st_q == ext_bus_pkg::BUS_SAMPLE) begin
			acc_go_q <= 1'b0;
		end
	end

	// transfers wait while reset, hold or host wide mode owns the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ext_bus_pkg::BUS_IDLE;
			rdata_q <= 16'h0000;
		end else begin
			unique case (st_q)
				ext_bus_pkg::BUS_IDLE: begin
					if (start) begin
						st_q <= ext_bus_pkg::BUS_DRIVE;
					end
				end
				// one extra cycle so read data has crossed both sync flops
				ext_bus_pkg::BUS_DRIVE: st_q <= ext_bus_pkg::BUS_SETTLE;
				ext_bus_pkg::BUS_SETTLE: st_q <= ext_bus_pkg::BUS_SAMPLE;
				ext_bus_pkg::BUS_SAMPLE: begin
					if (!acc_wr_q) rdata_q <= hdata_s2_q;
					st_q <= ext_bus_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// program counter model: reset vector and interrupt vectors
	assign irq.accept = irq.take && rs_n && hold_n && st_q == ext_bus_pkg::BUS_IDLE && !ack_q;
	// an accepted interrupt owns the address lines this cycle, so a transfer waits
	assign start = st_q == ext_bus_pkg::BUS_IDLE && acc_go_q && rs_n && hold_n && !wide && !ack_q
		&& !irq.accept;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= ext_bus_pkg::RESET_VECTOR;
			ack_q <= 1'b0;
			ack_vec_q <= 16'h0000;
		end else if (!rs_n) begin
			pc_q <= ext_bus_pkg::RESET_VECTOR;
			ack_q <= 1'b0;
		end else if (irq.accept) begin
			ack_q <= 1'b1;
			ack_vec_q <= irq.is_nmi ? ext_bus_pkg::NMI_VECTOR
				: ext_bus_pkg::IRQ_VECTOR_BASE + {12'h000, irq.idx, 2'b00};
			pc_q <= {7'h00, irq.is_nmi ? ext_bus_pkg::NMI_VECTOR
				: ext_bus_pkg::IRQ_VECTOR_BASE + {12'h000, irq.idx, 2'b00}};
		end else begin
			ack_q <= 1'b0;
			pc_q <= pc_q + 23'h000001;
		end
	end

	// pin drivers; holders keep the last level because outputs are not cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_addr_o <= 23'h000000;
			ext_addr_oe <= 23'h000000;
			ext_data_o <= 16'h0000;
			ext_data_oe <= 1'b0;
			ext_data_hold_en <= 1'b1;
			irq_ack_n_o <= 1'b1;
			irq_ack_n_oe <= 1'b0;
			hold_ack_n <= 1'b1;
		end else begin
			hold_ack_n <= hold_n || st_q != ext_bus_pkg::BUS_IDLE;
			ext_data_hold_en <= ctrl_q[ext_bus_pkg::CTRL_HOLDER];
			if (irq.accept) begin
				ext_addr_o <= {ext_addr_o[22:16], irq.is_nmi ? ext_bus_pkg::NMI_VECTOR
					: ext_bus_pkg::IRQ_VECTOR_BASE + {12'h000, irq.idx, 2'b00}};
			end else if (start) begin
				ext_addr_o <= acc_addr_q;
				ext_data_o <= wdata_q;
			end
			irq_ack_n_o <= !irq.accept;
			if (!off_ok) begin
				ext_addr_oe <= 23'h000000;
				ext_data_oe <= 1'b0;
				irq_ack_n_oe <= 1'b0;
			end else begin
				irq_ack_n_oe <= 1'b1;
				if (!hold_n && hold_ack_n == 1'b0) begin
					ext_addr_oe <= 23'h000000;
				end else if (wide) begin
					ext_addr_oe <= 23'h7F0000;
				end else begin
					ext_addr_oe <= 23'h7FFFFF;
				end
				ext_data_oe <= start && acc_wr_q;
				if ((st_q == ext_bus_pkg::BUS_DRIVE || st_q == ext_bus_pkg::BUS_SETTLE) && acc_wr_q
					&& hold_n && rs_n) begin
					ext_data_oe <= 1'b1;
				end
			end
		end
	end
endmodule

// File: ext_mem_model.sv
/* external memory stand-in on the data pins.
   assumes the bench resolves the address pins itself. */
`timescale 1ns/1ps
module ext_mem_model (
	input wire logic pclk,
	input wire logic [22:0] addr,
	input wire logic [22:0] addr_oe,
	input wire logic [15:0] dev_data,
	input wire logic dev_oe,
	output logic [15:0] data
);
	logic [15:0] last_q = 16'h0000;
	// a released bus toggles every cycle so a stale value never passes for read data
	always_ff @(posedge pclk) begin
		last_q <= data;
	end
	// read data is a pattern of the low address lines; device drive wins the wire
	assign data = dev_oe ? dev_data : (addr_oe[0] ? (addr[15:0] ^ 16'hA5A5) : ~last_q);
endmodule

// File: ext_bus_top_assertions.sv
/* pin-level checker for the external bus block.
   assumes it is bound to ext_bus_top and sees only its ports. */
`timescale 1ns/1ps
module ext_bus_top_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic reset_n,
	input wire logic hold_req_n,
	input wire logic hold_ack_n,
	input wire logic off_n,
	input wire logic host_wide_mode_pin,
	input wire logic [22:0] ext_addr_o,
	input wire logic [22:0] ext_addr_oe,
	input wire logic ext_data_oe,
	input wire logic ext_data_hold_en,
	input wire logic irq_ack_n_o,
	input wire logic irq_ack_n_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// level inputs pass sync flops, so a few cycles of slack are allowed
	off_float_a: assert property (
		!off_n [*4] |-> ext_addr_oe == 23'h0 && !ext_data_oe && !irq_ack_n_oe)
		else $error("outputs driven while disabled");
	hold_addr_a: assert property (
		!hold_ack_n [*2] |-> ext_addr_oe == 23'h0) else $error("address driven in hold");
	wide_addr_a: assert property (
		host_wide_mode_pin [*4] |-> ext_addr_oe[15:0] == 16'h0)
		else $error("low address driven in wide mode");
	reset_data_a: assert property (
		!reset_n [*4] |-> !ext_data_oe) else $error("data driven in reset");
	hold_data_a: assert property (
		!hold_req_n [*4] |-> !ext_data_oe) else $error("data driven in hold");
	ack_pulse_a: assert property (
		$fell(irq_ack_n_o) |=> irq_ack_n_o) else $error("acknowledge longer than a cycle");
	ack_vector_a: assert property (
		!irq_ack_n_o |-> ext_addr_o[15:0] == ext_bus_pkg::NMI_VECTOR
		|| ext_addr_o[15:4] == 12'hFFC) else $error("acknowledge off a vector");
	holder_ctrl_a: assert property (
		psel && penable && pready && pwrite && paddr == 8'h00 && reset_n
		|-> ##2 ext_data_hold_en == $past(pwdata[2], 2)) else $error("holder enable not updated");
endmodule
bind ext_bus_top ext_bus_top_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .paddr, .pwdata, .reset_n, .hold_req_n, .hold_ack_n, .off_n, .host_wide_mode_pin,
	.ext_addr_o, .ext_addr_oe, .ext_data_oe, .ext_data_hold_en, .irq_ack_n_o, .irq_ack_n_oe);

// File: ext_bus_top_tb.sv
/* self-checking bench for ext_bus_top over APB and its pins.
   assumes ext_mem_model answers on the data pins. */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module ext_bus_top_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, reset_n = 1;
	logic hold_req_n = 1, off_n = 1, host_wide_mode_pin = 0, nmi_n = 1, pready, pslverr;
	logic hold_ack_n, rd_err, ext_data_oe, ext_data_hold_en, irq_ack_n_o, irq_ack_n_oe;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] ext_irq_n = 4'hF;
	logic [22:0] ext_addr_i, ext_addr_o, ext_addr_oe;
	logic [15:0] ext_data_i, ext_data_o;
	int err_count = 0, check_count = 0;
	// undriven address lines show a host pattern, driven ones read back
	assign ext_addr_i = (ext_addr_o & ext_addr_oe) | (23'h001234 & ~ext_addr_oe);
	ext_bus_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .reset_n, .hold_req_n, .hold_ack_n, .off_n, .host_wide_mode_pin,
		.ext_addr_i, .ext_addr_o, .ext_addr_oe, .ext_data_i, .ext_data_o, .ext_data_oe,
		.ext_data_hold_en, .irq_ack_n_o, .irq_ack_n_oe, .ext_irq_n, .nmi_n);
	ext_mem_model mem_u (.pclk, .addr(ext_addr_o), .addr_oe(ext_addr_oe), .dev_data(ext_data_o),
		.dev_oe(ext_data_oe), .data(ext_data_i));
	initial begin
		forever #50 pclk = ~pclk;
	end
	task automatic close_out;
		if (err_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_ack(input logic [15:0] vec);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (irq_ack_n_o !== 1'b0 && n < 60);
		`CHK({irq_ack_n_o, ext_addr_o[15:0]}, {1'b0, vec})
		@(posedge pclk);
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, ext_bus_pkg::OFF_STATUS, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		`CHK(rd[0], 1'b0)
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ext_bus_pkg::OFF_CTRL, 32'h0);
		`CHK(rd, 32'h00000005)
		apb(1'b0, ext_bus_pkg::OFF_MASK, 32'h0);
		`CHK(rd, 32'h00000000)
		// globally masked here, so the request only latches
		ext_irq_n <= 4'hD;
		repeat (4) @(posedge pclk);
		ext_irq_n <= 4'hF;
		apb(1'b0, ext_bus_pkg::OFF_FLAG, 32'h0);
		`CHK(rd, 32'h00000002)
		apb(1'b1, ext_bus_pkg::OFF_FLAG, 32'h00000002);
		apb(1'b0, ext_bus_pkg::OFF_FLAG, 32'h0);
		`CHK(rd, 32'h00000000)
		nmi_n <= 1'b0;
		wait_ack(ext_bus_pkg::NMI_VECTOR);
		nmi_n <= 1'b1;
		apb(1'b1, ext_bus_pkg::OFF_CTRL, 32'h0);
		apb(1'b0, ext_bus_pkg::OFF_CTRL, 32'h0);
		`CHK(ext_data_hold_en, 1'b0)
		`CHK(rd, 32'h00000000)
		apb(1'b1, ext_bus_pkg::OFF_MASK, 32'h0000000F);
		ext_irq_n <= 4'h5;
		wait_ack(16'hFFC4);
		wait_ack(16'hFFCC);
		ext_irq_n <= 4'hF;
		// mode bit set: highest line is taken first
		apb(1'b1, ext_bus_pkg::OFF_CTRL, 32'h00000002);
		ext_irq_n <= 4'h5;
		wait_ack(16'hFFCC);
		wait_ack(16'hFFC4);
		ext_irq_n <= 4'hF;
		apb(1'b1, ext_bus_pkg::OFF_WDATA, 32'h0000BEEF);
		apb(1'b1, ext_bus_pkg::OFF_ACCESS, 32'h032A1234);
		for (int i = 0; i < 40 && ext_data_oe !== 1'b1; i++) @(posedge pclk);
		`CHK(ext_addr_o, 23'h2A1234)
		`CHK(ext_data_o, 16'hBEEF)
		wait_idle;
		apb(1'b1, ext_bus_pkg::OFF_ACCESS, 32'h00000100);
		wait_idle;
		apb(1'b0, ext_bus_pkg::OFF_RDATA, 32'h0);
		`CHK(rd, {16'h0000, 16'h0100 ^ 16'hA5A5})
		hold_req_n <= 1'b0;
		for (int i = 0; i < 40 && hold_ack_n !== 1'b0; i++) @(posedge pclk);
		@(posedge pclk);
		`CHK({hold_ack_n, ext_addr_oe}, 24'h000000)
		`CHK(ext_addr_o, 23'h000100)
		hold_req_n <= 1'b1;
		off_n <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK({ext_addr_oe, ext_data_oe, irq_ack_n_oe}, 25'h0000000)
		off_n <= 1'b1;
		host_wide_mode_pin <= 1'b1;
		// two sync flops and the output flop must pass before the pins turn
		repeat (4) @(posedge pclk);
		apb(1'b0, ext_bus_pkg::OFF_STATUS, 32'h0);
		`CHK({rd[3], ext_addr_oe}, {1'b1, 23'h7F0000})
		host_wide_mode_pin <= 1'b0;
		// unmapped offset answers with an error and zero data
		apb(1'b0, 8'h20, 32'h0);
		`CHK({rd_err, rd}, {1'b1, 32'h0})
		reset_n <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, ext_bus_pkg::OFF_PC, 32'h0);
		`CHK(rd, {9'h000, ext_bus_pkg::RESET_VECTOR})
		reset_n <= 1'b1;
		// pc leaves the vector one edge after the synchronised release
		repeat (4) @(posedge pclk);
		apb(1'b0, ext_bus_pkg::OFF_PC, 32'h0);
		`CHK(rd, {9'h000, ext_bus_pkg::RESET_VECTOR + 23'h000003})
		close_out;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		close_out;
	end
endmodule
